// file: design/sac_ctrl.sv
// Purpose: Select-mode successive approximation converter control with AXI4-Lite registers
// Assumes: Comparator decision comp_result is synchronous to aclk
// Notes: Half-LSB offset of the tap string is analog; the logic resolves the code only
`include "sac_map.svh"
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Code rounds input ratio to nearest step
// - Word result holds code times 64
// - Only select mode, one of six inputs
// - Start bit 7 begins conversion
// - Completion stores result, raises interrupt pulse
// - Conversions repeat while start bit set
// - Channel write restarts conversion from beginning
// - Start clear stops, keeps last result
// - Mode bit 0 enables comparator
// - Conversion time from mode bits 6..1
// - Channel from channel bits 2..0
// - Channel change to interrupt is conversion time plus one cycle
// - Result read beats result write
// - Config write cancels result write and interrupt
// - Stop mode halts all conversion
// - Byte result holds upper eight bits
// - Reset clears both result registers
// - Binary search MSB to LSB, ten bits
module sac_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic comp_result,
  input wire logic stop_mode,
  output logic comparator_en,
  output logic sampling,
  output logic [2:0] channel_sel,
  output logic [9:0] dac_code,
  output logic [5:0] analog_pin_en,
  output logic [5:0] port2_input_en,
  output logic conv_done_irq
);
  import sac_pkg::*;

  sac_state_t state_r;
  logic [7:0] converter_mode_reg_r;
  logic [7:0] channel_select_reg_r;
  logic [7:0] analog_pin_config_reg_r;
  logic [7:0] port2_direction_reg_r;
  logic [15:0] result_word_reg_r;
  logic [7:0] result_byte_reg_r;
  logic [9:0] approximation_reg_r;
  logic [3:0] bit_r;
  logic [3:0] presc_r;
  logic [3:0] ticks_r;
  logic wr_fire, rd_fire, wr_mode, wr_chan, wr_cfg, rd_res;
  logic tick, commit, restart;
  logic [3:0] ratio;
  logic [3:0] samp_len;

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  assign wr_fire = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wr_mode = wr_fire && s_axi_wstrb[0] && (s_axi_awaddr == `SAC_OFS_MODE);
  assign wr_chan = wr_fire && s_axi_wstrb[0] && (s_axi_awaddr == `SAC_OFS_CHAN);
  assign wr_cfg = wr_mode || wr_chan ||
                  (wr_fire && s_axi_wstrb[0] && (s_axi_awaddr == `SAC_OFS_PINCFG));
  assign rd_res = rd_fire &&
                  ((s_axi_araddr == `SAC_OFS_RESW) || (s_axi_araddr == `SAC_OFS_RESB));

  // Address and data taken together, one write outstanding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SAC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if ((s_axi_awaddr == `SAC_OFS_MODE) || (s_axi_awaddr == `SAC_OFS_CHAN) ||
          (s_axi_awaddr == `SAC_OFS_PINCFG) || (s_axi_awaddr == `SAC_OFS_P2DIR) ||
          (s_axi_awaddr == `SAC_OFS_RESW) || (s_axi_awaddr == `SAC_OFS_RESB)) begin
        s_axi_bresp <= `SAC_RESP_OKAY;
      end else begin
        s_axi_bresp <= `SAC_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    end
  end

  // Read data captured at the address edge, so a result write this cycle cannot tear it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SAC_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `SAC_RESP_OKAY;
      if (s_axi_araddr == `SAC_OFS_MODE) begin
        s_axi_rdata <= {24'h000000, converter_mode_reg_r};
      end else if (s_axi_araddr == `SAC_OFS_CHAN) begin
        s_axi_rdata <= {24'h000000, channel_select_reg_r};
      end else if (s_axi_araddr == `SAC_OFS_PINCFG) begin
        s_axi_rdata <= {24'h000000, analog_pin_config_reg_r};
      end else if (s_axi_araddr == `SAC_OFS_P2DIR) begin
        s_axi_rdata <= {24'h000000, port2_direction_reg_r};
      end else if (s_axi_araddr == `SAC_OFS_RESW) begin
        s_axi_rdata <= {16'h0000, result_word_reg_r};
      end else if (s_axi_araddr == `SAC_OFS_RESB) begin
        s_axi_rdata <= {24'h000000, result_byte_reg_r};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `SAC_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      converter_mode_reg_r <= `SAC_RST_MODE;
      channel_select_reg_r <= `SAC_RST_CHAN;
      analog_pin_config_reg_r <= `SAC_RST_PINCFG;
      port2_direction_reg_r <= `SAC_RST_P2DIR;
    end else if (wr_fire && s_axi_wstrb[0]) begin
      if (s_axi_awaddr == `SAC_OFS_MODE) begin
        converter_mode_reg_r <= s_axi_wdata[7:0];
      end else if (s_axi_awaddr == `SAC_OFS_CHAN) begin
        channel_select_reg_r <= {5'h00, s_axi_wdata[`SAC_CHAN_HI:0]};
      end else if (s_axi_awaddr == `SAC_OFS_PINCFG) begin
        analog_pin_config_reg_r <= {5'h00, s_axi_wdata[`SAC_PINCFG_HI:0]};
      end else if (s_axi_awaddr == `SAC_OFS_P2DIR) begin
        port2_direction_reg_r <= {2'h3, s_axi_wdata[`SAC_P2DIR_HI:0]};
      end
    end
  end

  // ****************************************
  // Conversion timing
  // ****************************************
  assign ratio = converter_mode_reg_r[`SAC_RATIO_HI:`SAC_RATIO_LO];
  assign samp_len = `SAC_SAMPLE_TICKS +
                    {2'h0, converter_mode_reg_r[`SAC_LEVEL_HI:`SAC_LEVEL_LO]};
  assign tick = (presc_r == ratio);
  // Restart follows the running start bit, not bit 7 of the channel data
  assign restart = wr_chan && converter_mode_reg_r[`SAC_MODE_START] && !stop_mode;
  // Tap follows the trial register directly; a late copy would feed stale taps
  assign dac_code = approximation_reg_r;
  assign commit = (state_r == SAC_DONE) && !rd_res && !wr_cfg && !stop_mode;

  // Prescaler of ratio+1 clocks per tick, cleared whenever a phase starts over
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_r <= 4'h0;
    end else if (state_r == SAC_IDLE || state_r == SAC_DONE || restart || tick) begin
      presc_r <= 4'h0;
    end else begin
      presc_r <= presc_r + 4'h1;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= SAC_IDLE;
      ticks_r <= 4'h0;
      bit_r <= 4'h0;
      approximation_reg_r <= 10'h000;
    end else if (stop_mode) begin
      state_r <= SAC_IDLE;
    end else if (wr_mode && !s_axi_wdata[`SAC_MODE_START]) begin
      state_r <= SAC_IDLE;
    end else if (wr_chan && converter_mode_reg_r[`SAC_MODE_START]) begin
      state_r <= SAC_SAMPLE;
      ticks_r <= 4'h0;
    end else begin
      case (state_r)
        SAC_IDLE: begin
          ticks_r <= 4'h0;
          if (converter_mode_reg_r[`SAC_MODE_START]) begin
            state_r <= SAC_SAMPLE;
          end
        end
        SAC_SAMPLE: begin
          if (tick) begin
            if (ticks_r == samp_len - 4'h1) begin
              state_r <= SAC_CONV;
              approximation_reg_r <= `SAC_SAR_SEED;
              bit_r <= `SAC_SAR_MSB;
            end else begin
              ticks_r <= ticks_r + 4'h1;
            end
          end
        end
        SAC_CONV: begin
          if (tick) begin
            // Comparator high keeps the trial bit, low drops it
            approximation_reg_r[bit_r] <= comp_result;
            if (bit_r == 4'h0) begin
              state_r <= SAC_DONE;
            end else begin
              approximation_reg_r[bit_r - 4'h1] <= 1'b1;
              bit_r <= bit_r - 4'h1;
            end
          end
        end
        SAC_DONE: begin
          // A colliding result read holds the write back one cycle
          if (!rd_res || wr_cfg) begin
            ticks_r <= 4'h0;
            state_r <= SAC_SAMPLE;
          end
        end
        default: begin
          state_r <= SAC_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Result store
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_word_reg_r <= `SAC_RST_RESW;
      result_byte_reg_r <= `SAC_RST_RESB;
      conv_done_irq <= 1'b0;
    end else begin
      conv_done_irq <= commit;
      if (commit) begin
        result_word_reg_r <= {approximation_reg_r, 6'h00};
        result_byte_reg_r <= approximation_reg_r[9:2];
      end
    end
  end

  // ****************************************
  // Analog front end controls
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comparator_en <= 1'b0;
      sampling <= 1'b0;
      channel_sel <= 3'h0;
      analog_pin_en <= 6'h00;
      port2_input_en <= 6'h3f;
    end else begin
      comparator_en <= converter_mode_reg_r[`SAC_MODE_CE];
      sampling <= (state_r == SAC_SAMPLE);
      channel_sel <= channel_select_reg_r[`SAC_CHAN_HI:0];
      analog_pin_en <= 6'h3f >> analog_pin_config_reg_r[`SAC_PINCFG_HI:0];
      port2_input_en <= port2_direction_reg_r[`SAC_P2DIR_HI:0];
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_sar_seeded;
    approximation_reg_r == `SAC_SAR_SEED && bit_r == `SAC_SAR_MSB;
  endsequence

  sequence s_commit_store;
    conv_done_irq && result_word_reg_r[5:0] == 6'h00;
  endsequence

  a_result_format: assert property (@(posedge aclk) disable iff (!aresetn)
    commit |=> s_commit_store ##0 result_word_reg_r[15:6] == $past(approximation_reg_r))
    else $error("result word not code times 64");

  a_byte_upper: assert property (@(posedge aclk) disable iff (!aresetn)
    result_byte_reg_r == result_word_reg_r[15:8])
    else $error("byte result differs from word upper bits");

  a_sar_seed: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(state_r == SAC_CONV) |-> s_sar_seeded)
    else $error("search did not start at MSB");

  a_stop_halts: assert property (@(posedge aclk) disable iff (!aresetn)
    stop_mode |=> state_r == SAC_IDLE && !conv_done_irq)
    else $error("conversion active in stop mode");

  a_start_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_mode && !s_axi_wdata[7] |=> state_r == SAC_IDLE ##1 $stable(result_word_reg_r))
    else $error("start clear did not stop");

  a_chan_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_chan && converter_mode_reg_r[7] && !stop_mode && !wr_mode |=>
    state_r == SAC_SAMPLE && ticks_r == 4'h0)
    else $error("channel write did not restart");

  a_cfg_cancels: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == SAC_DONE && wr_cfg |=> !conv_done_irq && $stable(result_word_reg_r))
    else $error("config write let result through");

  a_read_first: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == SAC_DONE && rd_res && !wr_cfg && !stop_mode |=>
    $stable(result_word_reg_r) && state_r == SAC_DONE)
    else $error("result write beat a read");

  a_repeat_conv: assert property (@(posedge aclk) disable iff (!aresetn)
    commit && converter_mode_reg_r[7] && !stop_mode |=> state_r == SAC_SAMPLE)
    else $error("next conversion not started");

  a_irq_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_done_irq |=> !conv_done_irq)
    else $error("interrupt longer than one cycle");

  a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
endmodule
`default_nettype wire

// file: design/sac_map.svh
// Purpose: Register map, reset values and timing counts of the converter control
// Assumes: 8-bit byte address taken from the AXI4-Lite address
// Notes: Definitions only
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define SAC_OFS_MODE 8'h00
`define SAC_OFS_CHAN 8'h04
`define SAC_OFS_PINCFG 8'h08
`define SAC_OFS_P2DIR 8'h0c
`define SAC_OFS_RESW 8'h10
`define SAC_OFS_RESB 8'h14
// ****************************************
// Field positions
// ****************************************
`define SAC_MODE_START 7
`define SAC_MODE_CE 0
`define SAC_RATIO_HI 6
`define SAC_RATIO_LO 3
`define SAC_LEVEL_HI 2
`define SAC_LEVEL_LO 1
`define SAC_CHAN_HI 2
`define SAC_PINCFG_HI 2
`define SAC_P2DIR_HI 5
`define SAC_RES_SHIFT 6
// ****************************************
// Reset values
// ****************************************
`define SAC_RST_MODE 8'h00
`define SAC_RST_CHAN 8'h00
`define SAC_RST_PINCFG 8'h00
`define SAC_RST_P2DIR 8'hff
`define SAC_RST_RESW 16'h0000
`define SAC_RST_RESB 8'h00
// ****************************************
// Timing counts, search seed and response codes
// ****************************************
`define SAC_SAMPLE_TICKS 4'h4
`define SAC_SAR_MSB 4'h9
`define SAC_SAR_SEED 10'h200
`define SAC_RESP_OKAY 2'h0
`define SAC_RESP_SLVERR 2'h2
`endif

// file: design/sac_pkg.sv
// Purpose: Types shared by the converter control
// Assumes: Nothing
// Notes: Gray-coded state path idle, sample, convert, done
package sac_pkg;
  typedef enum logic [1:0] {
    SAC_IDLE = 2'h0,
    SAC_SAMPLE = 2'h1,
    SAC_CONV = 2'h3,
    SAC_DONE = 2'h2
  } sac_state_t;
endpackage

// file: verification/sac_front_model.sv
// Purpose: Analog comparator front end seen by the converter control
// Assumes: Input levels are given as ideal codes, already rounded
// Notes: Unpowered comparator gives a toggling, useless decision
`timescale 1ns/1ps
`default_nettype none
module sac_front_model (
  input wire logic aclk,
  input wire logic sampling,
  input wire logic comparator_en,
  input wire logic [2:0] channel_sel,
  input wire logic [9:0] dac_code,
  output logic comp_result
);
  // Six inputs, extremes included
  logic [9:0] lvl [0:5] = '{10'h000, 10'h3ff, 10'h2a5, 10'h15a, 10'h001, 10'h200};
  logic [9:0] held_r = 10'h000;
  logic tog_r = 1'b0;
  always_ff @(posedge aclk) begin
    tog_r <= ~tog_r;
    if (sampling) begin
      held_r <= (channel_sel < 3'h6) ? lvl[channel_sel] : ~held_r;
    end
  end
  // Held level against tap, one decision per trial
  assign comp_result = comparator_en ? (held_r >= dac_code) : tog_r;
endmodule
`default_nettype wire

// file: verification/testbench.sv
// Purpose: Register-level test of the converter control
// Assumes: Ratio 0 and level 0 give T cycles a conversion
// Notes: Front end model supplies comparator decisions
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sac_pkg::*;
  localparam int T = 15;
  logic aclk = 0, aresetn = 0, stop_mode = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, rd_d;
  logic [3:0] wstrb = 0;
  logic awready, wready, bvalid, arready, rvalid, comp, ce, samp, irq;
  logic [1:0] bresp, rresp, rd_r, wr_r;
  logic [2:0] chsel;
  logic [9:0] dac;
  logic [5:0] pin_en, p2_en;
  logic [9:0] lvl [0:5] = '{10'h000, 10'h3ff, 10'h2a5, 10'h15a, 10'h001, 10'h200};
  logic [7:0] modes [0:2] = '{8'h8b, 8'h93, 8'hff};
  int fail_count = 0, compares = 0, cyc = 0, irq_cnt = 0, irq_cyc = 0, wr_cyc = 0;

  sac_ctrl i_sac_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .comp_result(comp), .stop_mode(stop_mode),
    .comparator_en(ce), .sampling(samp), .channel_sel(chsel), .dac_code(dac),
    .analog_pin_en(pin_en), .port2_input_en(p2_en), .conv_done_irq(irq));
  sac_front_model i_sac_front_model (.aclk(aclk), .sampling(samp), .comparator_en(ce),
    .channel_sel(chsel), .dac_code(dac), .comp_result(comp));

  initial forever #10 aclk = ~aclk;

  // ****************************************
  // Cycle count, interrupt log, hang guard
  // ****************************************
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) begin
      irq_cnt <= irq_cnt + 1;
      irq_cyc <= cyc;
    end
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("Compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic ok(input logic c);
    chk({31'h0, c}, 32'h1);
  endtask

  // ****************************************
  // AXI4-Lite master
  // ****************************************
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin
        awvalid <= 1'b0;
        wr_cyc = cyc;
      end
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr_chk(input logic [7:0] a, input logic [7:0] d, input logic [1:0] xr);
    axi_wr(a, d, wr_r);
    chk({30'h0, wr_r}, {30'h0, xr});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic [1:0] xr);
    axi_rd(a, rd_d, rd_r);
    chk(rd_d, x);
    chk({30'h0, rd_r}, {30'h0, xr});
  endtask

  task automatic wait_irq(input int maxc);
    int n0;
    n0 = irq_cnt;
    repeat (maxc) if (irq_cnt == n0) @(posedge aclk);
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    int e, tt, n0, cancels;
    logic [7:0] m;
    cancels = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(8'h10, 32'h0, 2'h0);
    rd_chk(8'h14, 32'h0, 2'h0);
    rd_chk(8'h0c, 32'hff, 2'h0);
    rd_chk(8'h3c, 32'h0, 2'h2);
    wr_chk(8'h3c, 8'h5a, 2'h2);
    wr_chk(8'h10, 8'h55, 2'h0);
    rd_chk(8'h10, 32'h0, 2'h0);
    wr_chk(8'h08, 8'h03, 2'h0);
    @(posedge aclk);
    ok(pin_en === 6'h07);
    wr_chk(8'h08, 8'h00, 2'h0);
    wr_chk(8'h0c, 8'h2a, 2'h0);
    @(posedge aclk);
    ok(p2_en === 6'h2a);
    rd_chk(8'h0c, 32'hea, 2'h0);
    $display("Test registers done");
    wr_chk(8'h00, 8'h01, 2'h0);
    @(posedge aclk);
    ok(ce === 1'b1);
    // Comparator settles for 1 us before start
    repeat (50) @(posedge aclk);
    wr_chk(8'h04, 8'h02, 2'h0);
    wr_chk(8'h00, 8'h81, 2'h0);
    e = wr_cyc;
    wait_irq(T + 6);
    chk(irq_cyc - e, T + 2);
    rd_chk(8'h10, 32'ha940, 2'h0);
    rd_chk(8'h14, 32'ha9, 2'h0);
    n0 = irq_cnt;
    wait_irq(T + 6);
    ok(irq_cnt != n0);
    $display("Test start done");
    for (int c = 0; c < 6; c++) begin
      repeat (4) @(posedge aclk);
      wr_chk(8'h04, 8'(c), 2'h0);
      wait_irq(T + 6);
      chk(irq_cyc - wr_cyc, T + 1);
      ok(chsel === 3'(c));
      rd_chk(8'h10, {16'h0, lvl[c], 6'h0}, 2'h0);
      rd_chk(8'h14, {24'h0, lvl[c][9:2]}, 2'h0);
    end
    $display("Test channels done");
    for (int i = 0; i < 3; i++) begin
      m = modes[i];
      wr_chk(8'h00, 8'h01, 2'h0);
      wr_chk(8'h00, m, 2'h0);
      e = wr_cyc;
      tt = (int'(m[6:3]) + 1) * (14 + int'(m[2:1])) + 1;
      wait_irq(tt + 6);
      chk(irq_cyc - e, tt + 2);
      rd_chk(8'h10, 32'h8000, 2'h0);
    end
    $display("Test timing done");
    // New channel in flight, so a missed stop would change the result
    wr_chk(8'h04, 8'h03, 2'h0);
    repeat (9) @(posedge aclk);
    wr_chk(8'h00, 8'h01, 2'h0);
    n0 = irq_cnt;
    repeat (600) @(posedge aclk);
    ok(irq_cnt == n0);
    rd_chk(8'h10, 32'h8000, 2'h0);
    $display("Test stop done");
    wr_chk(8'h00, 8'h81, 2'h0);
    repeat (5) @(posedge aclk);
    stop_mode <= 1'b1;
    n0 = irq_cnt;
    repeat (60) @(posedge aclk);
    ok(irq_cnt == n0);
    // Flag lives outside the block; restart needs nothing more here
    stop_mode <= 1'b0;
    wait_irq(T + 8);
    ok(irq_cnt != n0);
    rd_chk(8'h10, 32'h5680, 2'h0);
    $display("Test standby done");
    // Sweep a config write or result read across the commit cycle
    for (int j = 0; j < 16; j++) begin
      wr_chk(8'h04, 8'h01, 2'h0);
      wait_irq(T + 6);
      n0 = irq_cnt;
      wr_chk(8'h04, 8'h02, 2'h0);
      e = wr_cyc;
      repeat (8 + j / 2) @(posedge aclk);
      if (j % 2) axi_rd(8'h10, rd_d, rd_r);
      else wr_chk(8'h08, 8'h00, 2'h0);
      while (cyc < e + T + 5) @(posedge aclk);
      if (j % 2) begin
        chk(rd_d, (j <= 7) ? 32'hffc0 : 32'ha940);
        chk(irq_cyc - e, (j == 7) ? T + 2 : T + 1);
      end else if (irq_cnt == n0) begin
        cancels++;
        rd_chk(8'h10, 32'hffc0, 2'h0);
      end else begin
        chk(irq_cyc - e, T + 1);
      end
    end
    chk(cancels, 1);
    $display("Test collisions done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
